// ==== include/ltx_pkg.sv ====
// Purpose: constants for the loop, thread and increment execution block
// Assumes: one clock, opcodes fetched by the surrounding core
// Notes:   cycle counts are core clock cycles per instruction
package ltx_pkg;
    localparam logic [3:0] NIB_CNT_BR   = 4'hA;
    localparam logic [3:0] NIB_INC_R    = 4'hE;
    localparam logic [7:0] OP_IRQ_ON    = 8'h9F;
    localparam logic [7:0] OP_IRQ_OFF   = 8'h8F;
    localparam logic [7:0] OP_ENTER     = 8'h1F;
    localparam logic [7:0] OP_EXIT      = 8'h2F;
    localparam logic [7:0] OP_HALT      = 8'h6F;
    localparam logic [7:0] OP_INC       = 8'h20;
    localparam logic [7:0] OP_INC_IR    = 8'h21;
    localparam logic [7:0] OP_ADD1_W    = 8'hA0;
    localparam logic [4:0] CYC_CNT_BR   = 5'h08;
    localparam logic [4:0] CYC_SHORT    = 5'h04;
    localparam logic [4:0] CYC_THREAD   = 5'h0E;
    localparam logic [4:0] CYC_ADD1_W   = 5'h08;
    localparam logic [15:0] RST_PC      = 16'h0000;
    localparam logic [15:0] RST_TP      = 16'h0000;
    localparam logic [15:0] RST_STK     = 16'h0000;
    localparam logic [7:0]  RST_MODE    = 8'h00;
    localparam logic [15:0] STACK_STEP  = 16'h0002;
    localparam logic [15:0] WORD_STEP   = 16'h0002;
    localparam logic [15:0] CNT_BR_LEN  = 16'h0002;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WAIT   = 3'b001,
        ST_DONE   = 3'b010,
        ST_HALTED = 3'b011
    } ltx_state_t;
endpackage : ltx_pkg

// ==== design/ltx_exec.sv ====
// Purpose: executes count-down branch, irq on/off, thread call/return,
//          core-clock halt and byte/word add-one
// Assumes: operand data (register, pair, memory word, stack word) is on the
//          inputs when start is pulsed; flags register owned by the core
// Notes:   results are registered at the taking edge and held until the next instruction; done pulses for one cycle
`timescale 1ns/1ps
`default_nettype none
module ltx_exec (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  disp,
    input  wire logic [7:0]  opnd_hi,
    input  wire logic [7:0]  opnd_lo,
    input  wire logic [15:0] mem_word,
    input  wire logic [15:0] stack_word,
    input  wire logic [15:0] pc_in,
    input  wire logic [7:0]  flags_in,
    input  wire logic        irq_req,
    input  wire logic        irq_pending,
    output logic             done,
    output logic [15:0]      pc_out,
    output logic [7:0]       res_hi,
    output logic [7:0]       res_lo,
    output logic             res_wr,
    output logic             res_word,
    output logic [3:0]       work_reg,
    output logic [7:0]       flags_out,
    output logic [15:0]      thread_ptr,
    output logic [15:0]      stack_ptr,
    output logic [15:0]      push_word,
    output logic             push_wr,
    output logic [7:0]       sys_mode,
    output logic             irq_service,
    output logic             cpu_clk_en,
    output logic             busy
);
    typedef struct packed {
        ltx_pkg::ltx_state_t st;
        logic [4:0]  cnt;
        logic        done;
        logic [15:0] pc;
        logic [7:0]  rh;
        logic [7:0]  rl;
        logic        rwr;
        logic        rword;
        logic [3:0]  wreg;
        logic [7:0]  flg;
        logic [15:0] tp;
        logic [15:0] stk;
        logic [15:0] push;
        logic        pwr;
        logic [7:0]  mode;
        logic        svc;
        logic        clken;
        logic        bsy;
        logic        irq_s1;
        logic        irq_s2;
    } ltx_regs_t;

    ltx_regs_t r_ff;
    ltx_regs_t nxt_r;

    function automatic logic [7:0] upd_flags(input logic [7:0] f, input logic z,
                                             input logic s, input logic v);
        logic [7:0] o;
        o = f;
        o[ltx_pkg::FLAG_Z] = z;
        o[ltx_pkg::FLAG_S] = s;
        o[ltx_pkg::FLAG_V] = v;
        return o;
    endfunction : upd_flags

    logic [7:0]  dec_r;
    logic [7:0]  inc_b;
    logic [15:0] inc_w;
    logic [15:0] disp_ext;
    logic [15:0] next_pc;

    always_comb begin
        dec_r    = opnd_lo - 8'h01;
        inc_b    = opnd_lo + 8'h01;
        inc_w    = {opnd_hi, opnd_lo} + 16'h0001;
        disp_ext = {{8{disp[7]}}, disp};
        next_pc  = pc_in + ltx_pkg::CNT_BR_LEN;
    end

    always_comb begin
        nxt_r        = r_ff;
        nxt_r.done   = 1'b0;
        nxt_r.rwr    = 1'b0;
        nxt_r.pwr    = 1'b0;
        nxt_r.irq_s1 = irq_req;
        nxt_r.irq_s2 = r_ff.irq_s1;
        // serviced only while enabled; pending bits kept outside
        nxt_r.svc    = r_ff.mode[0] & irq_pending;
        case (r_ff.st)
            ltx_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_r.st    = ltx_pkg::ST_WAIT;
                    nxt_r.flg   = flags_in;
                    nxt_r.pc    = pc_in;
                    nxt_r.rword = 1'b0;
                    nxt_r.wreg  = opcode[7:4];
                    nxt_r.cnt   = ltx_pkg::CYC_SHORT - 5'h02;
                    if (opcode[3:0] == ltx_pkg::NIB_CNT_BR) begin
                        nxt_r.cnt = ltx_pkg::CYC_CNT_BR - 5'h02;
                        nxt_r.rl  = dec_r;
                        nxt_r.rwr = 1'b1;
                        nxt_r.pc  = (dec_r != 8'h00) ? next_pc + disp_ext : next_pc;
                    end else if (opcode[3:0] == ltx_pkg::NIB_INC_R ||
                                 opcode == ltx_pkg::OP_INC ||
                                 opcode == ltx_pkg::OP_INC_IR) begin
                        nxt_r.rl  = inc_b;
                        nxt_r.rwr = 1'b1;
                        nxt_r.flg = upd_flags(flags_in, inc_b == 8'h00, inc_b[7],
                                              inc_b == 8'h80);
                    end else if (opcode == ltx_pkg::OP_ADD1_W) begin
                        nxt_r.cnt   = ltx_pkg::CYC_ADD1_W - 5'h02;
                        nxt_r.rh    = inc_w[15:8];
                        nxt_r.rl    = inc_w[7:0];
                        nxt_r.rwr   = 1'b1;
                        nxt_r.rword = 1'b1;
                        nxt_r.flg   = upd_flags(flags_in, inc_w == 16'h0000, inc_w[15],
                                                inc_w == 16'h8000);
                    end else if (opcode == ltx_pkg::OP_IRQ_ON) begin
                        nxt_r.mode[0] = 1'b1;
                    end else if (opcode == ltx_pkg::OP_IRQ_OFF) begin
                        nxt_r.mode[0] = 1'b0;
                    end else if (opcode == ltx_pkg::OP_ENTER) begin
                        nxt_r.cnt  = ltx_pkg::CYC_THREAD - 5'h02;
                        nxt_r.stk  = r_ff.stk - ltx_pkg::STACK_STEP;
                        nxt_r.push = r_ff.tp;
                        nxt_r.pwr  = 1'b1;
                        nxt_r.pc   = mem_word;
                        nxt_r.tp   = pc_in + ltx_pkg::WORD_STEP;
                    end else if (opcode == ltx_pkg::OP_EXIT) begin
                        nxt_r.cnt = ltx_pkg::CYC_THREAD - 5'h02;
                        nxt_r.stk = r_ff.stk + ltx_pkg::STACK_STEP;
                        nxt_r.pc  = mem_word;
                        nxt_r.tp  = stack_word + ltx_pkg::WORD_STEP;
                    end else if (opcode == ltx_pkg::OP_HALT) begin
                        nxt_r.st    = ltx_pkg::ST_HALTED;
                        nxt_r.clken = 1'b0;
                    end
                end
            end
            ltx_pkg::ST_WAIT: begin
                if (r_ff.cnt == 5'h00) begin
                    nxt_r.st = ltx_pkg::ST_DONE;
                end else begin
                    nxt_r.cnt = r_ff.cnt - 5'h01;
                end
            end
            ltx_pkg::ST_DONE: begin
                nxt_r.done = 1'b1;
                nxt_r.st   = ltx_pkg::ST_IDLE;
            end
            ltx_pkg::ST_HALTED: begin
                if (r_ff.irq_s2) begin
                    nxt_r.clken = 1'b1;
                    nxt_r.st    = ltx_pkg::ST_DONE;
                end
            end
            default: nxt_r.st = ltx_pkg::ST_IDLE;
        endcase
        // busy kept as a flop so the output needs no decode
        nxt_r.bsy = (nxt_r.st != ltx_pkg::ST_IDLE);
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            r_ff       <= '0;
            r_ff.st    <= ltx_pkg::ST_IDLE;
            r_ff.pc    <= ltx_pkg::RST_PC;
            r_ff.tp    <= ltx_pkg::RST_TP;
            r_ff.stk   <= ltx_pkg::RST_STK;
            r_ff.mode  <= ltx_pkg::RST_MODE;
            r_ff.clken <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    always_comb begin
        done        = r_ff.done;
        pc_out      = r_ff.pc;
        res_hi      = r_ff.rh;
        res_lo      = r_ff.rl;
        res_wr      = r_ff.rwr;
        res_word    = r_ff.rword;
        work_reg    = r_ff.wreg;
        flags_out   = r_ff.flg;
        thread_ptr  = r_ff.tp;
        stack_ptr   = r_ff.stk;
        push_word   = r_ff.push;
        push_wr     = r_ff.pwr;
        sys_mode    = r_ff.mode;
        irq_service = r_ff.svc;
        cpu_clk_en  = r_ff.clken;
        busy        = r_ff.bsy;
    end

    sequence s_start_cbr;
        start && r_ff.st == ltx_pkg::ST_IDLE && opcode[3:0] == ltx_pkg::NIB_CNT_BR;
    endsequence
    // done is registered, so it is sampled high one edge after it is set
    sequence s_done_after8;
        (!done)[*8] ##1 done;
    endsequence

    a_cbr_timing: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_start_cbr |=> s_done_after8) else $error("count-down branch not 8 cycles");
    a_cbr_target: assert property (@(posedge ref_clk) disable iff (!rstn)
        s_start_cbr and (opnd_lo == 8'h01) |=> pc_out == $past(pc_in) + 16'h0002)
        else $error("count-down branch fall-through wrong");
    a_irq_on_bit: assert property (@(posedge ref_clk) disable iff (!rstn)
        start && !busy && opcode == ltx_pkg::OP_IRQ_ON |=> sys_mode[0] ##4 done)
        else $error("irq on did not set mode bit");
    a_enter_stack: assert property (@(posedge ref_clk) disable iff (!rstn)
        start && !busy && opcode == ltx_pkg::OP_ENTER
        |=> stack_ptr == $past(stack_ptr) - 16'h0002 && push_wr)
        else $error("thread call stack wrong");
    a_thread_time: assert property (@(posedge ref_clk) disable iff (!rstn)
        start && !busy && (opcode == ltx_pkg::OP_ENTER || opcode == ltx_pkg::OP_EXIT)
        |=> ##14 done) else $error("thread op not 14 cycles");
    a_halt_clock: assert property (@(posedge ref_clk) disable iff (!rstn)
        start && !busy && opcode == ltx_pkg::OP_HALT |=> !cpu_clk_en)
        else $error("halt did not stop clock");
    a_halt_wake: assert property (@(posedge ref_clk) disable iff (!rstn)
        !cpu_clk_en && irq_req |-> ##[1:3] cpu_clk_en) else $error("halt not released");
    a_svc_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        irq_service |-> $past(sys_mode[0])) else $error("serviced while disabled");
    a_flags_keep: assert property (@(posedge ref_clk) disable iff (!rstn)
        start && !busy && opcode == ltx_pkg::OP_ENTER |=> flags_out == $past(flags_in))
        else $error("flags changed");
    a_inc_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
        start && !busy && opcode == ltx_pkg::OP_INC && opnd_lo == 8'hFF
        |=> flags_out[6] && res_lo == 8'h00) else $error("add-one zero flag wrong");
endmodule : ltx_exec
`default_nettype wire

// ==== bench/ltx_far_model.sv ====
// Purpose: far-side model of program memory and stack
// Assumes: opcode is held on the bus for the whole instruction
// Notes:   stack is a queue of pushed thread pointers; empty stack reads
//          the inverse of the last pushed word
`timescale 1ns/1ps
`default_nettype none
module ltx_far_model (
    input  wire logic        ref_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  opcode,
    input  wire logic [15:0] pc_in,
    input  wire logic [15:0] push_word,
    input  wire logic        push_wr,
    input  wire logic        done,
    input  wire logic        start,
    input  wire logic        busy,
    output logic [15:0]      mem_word,
    output logic [15:0]      stack_word
);
    logic [15:0] stk[$];
    logic [15:0] fetch_addr;
    logic [15:0] top_ff;
    logic        pop_due_ff;
    // pop one edge after a return is taken, so the taking edge sees a stable top
    always @(posedge ref_clk) begin
        if (!rstn) begin
            stk.delete();
            pop_due_ff <= 1'b0;
            top_ff     <= 16'hFFFF;
        end else begin
            pop_due_ff <= start && !busy && opcode == ltx_pkg::OP_EXIT;
            if (push_wr) begin
                stk.push_back(push_word);
                top_ff <= push_word;
            end else if (pop_due_ff) begin
                if (stk.size() > 0) void'(stk.pop_back());
                top_ff <= (stk.size() > 0) ? stk[stk.size()-1] : ~push_word;
            end
        end
    end
    always @* begin
        stack_word = top_ff;
        fetch_addr = (opcode == ltx_pkg::OP_EXIT) ? stack_word : pc_in;
        mem_word   = {fetch_addr[7:0] ^ 8'h3C, fetch_addr[15:8] + 8'h10};
    end
endmodule : ltx_far_model
`default_nettype wire

// ==== bench/loop_thread_incr_instr_exec_tb.sv ====
// Purpose: self-checking bench for the loop, thread and add-one executor
// Assumes: program word at address a is {a[7:0]^3C, a[15:8]+10}
// Notes:   one instruction at a time, cycles counted from the taking edge
`timescale 1ns/1ps
`default_nettype none
module loop_thread_incr_instr_exec_tb;
    logic        ref_clk = 1'b0, rstn = 1'b0, start = 1'b0, irq_req = 1'b0, irq_pending = 1'b0;
    logic [7:0]  opcode = 8'h00, disp = 8'h00, opnd_hi = 8'h00, opnd_lo = 8'h00;
    logic [7:0]  flags_in = 8'h00, res_hi, res_lo, flags_out, sys_mode;
    logic [15:0] pc_in = 16'h0000, mem_word, stack_word, pc_out, thread_ptr, stack_ptr;
    logic [15:0] push_word;
    logic        done, res_wr, res_word, push_wr, irq_service, cpu_clk_en, busy;
    logic [3:0]  work_reg;
    logic        wr_seen, pw_seen, bsy_seen;
    int          fails = 0, cmp_count = 0, cyc = 0;
    ltx_exec dut_u (.ref_clk, .rstn, .start, .opcode, .disp, .opnd_hi, .opnd_lo, .mem_word,
        .stack_word, .pc_in, .flags_in, .irq_req, .irq_pending, .done, .pc_out, .res_hi,
        .res_lo, .res_wr, .res_word, .work_reg, .flags_out, .thread_ptr, .stack_ptr,
        .push_word, .push_wr, .sys_mode, .irq_service, .cpu_clk_en, .busy);
    ltx_far_model far_u (.ref_clk, .rstn, .opcode, .pc_in, .push_word, .push_wr, .done,
        .start, .busy, .mem_word, .stack_word);
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            stop_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic setup(input logic [7:0] d, hi, lo, fl, input logic [15:0] pc);
        disp <= d;
        opnd_hi <= hi;
        opnd_lo <= lo;
        flags_in <= fl;
        pc_in <= pc;
    endtask : setup
    // issue one instruction and count cycles until done
    task automatic run(input logic [7:0] op, input logic [15:0] n);
        int c;
        opcode <= op;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        #1;
        wr_seen = res_wr;
        pw_seen = push_wr;
        bsy_seen = busy;
        c = 0;
        do begin
            @(posedge ref_clk);
            #1;
            c++;
            if (op == ltx_pkg::OP_HALT && c == 6) begin
                check(16'(cpu_clk_en), 16'h0000);
                irq_req <= 1'b1;
            end
        end while (done !== 1'b1 && c < 40);
        check(16'(done), 16'h0001);
        check({7'h00, bsy_seen, 7'h00, busy}, 16'h0100);
        if (n != 16'h0000) check(16'(c), n);
    endtask : run
    task automatic cnt_branch(input logic [7:0] op, d, r, input logic [15:0] pc, exp_pc);
        setup(d, 8'h00, r, 8'hFF, pc);
        run(op, 16'h0008);
        check({8'h00, r - 8'h01}, 16'(res_lo));
        check(16'(wr_seen), 16'h0001);
        check(pc_out, exp_pc);
        check(16'(work_reg), 16'(op[7:4]));
        check(16'(flags_out), 16'h00FF);
    endtask : cnt_branch
    task automatic thread(input logic [7:0] op, input logic [15:0] pc, tp, sp, pcx);
        setup(8'h00, 8'h00, 8'h00, 8'h5A, pc);
        run(op, 16'h000E);
        check(16'(pw_seen), 16'(op == ltx_pkg::OP_ENTER));
        check(thread_ptr, tp);
        check(stack_ptr, sp);
        check(pc_out, pcx);
        check(16'(flags_out), 16'h005A);
    endtask : thread
    task automatic stop_test;
        $display("fails=%0d cmp_count=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        #1;
        check(16'(sys_mode), 16'h0000);
        check(16'(cpu_clk_en), 16'h0001);
        cnt_branch(8'h3A, 8'h80, 8'h02, 16'h1000, 16'h0F82);
        cnt_branch(8'hCA, 8'h7F, 8'h00, 16'h2000, 16'h2081);
        cnt_branch(8'h0A, 8'h80, 8'h01, 16'h3000, 16'h3002);
        irq_pending <= 1'b1;
        run(ltx_pkg::OP_IRQ_OFF, 16'h0004);
        repeat (2) @(posedge ref_clk);
        #1;
        check(16'(irq_service), 16'h0000);
        run(ltx_pkg::OP_IRQ_ON, 16'h0004);
        check(16'(sys_mode), 16'h0001);
        repeat (2) @(posedge ref_clk);
        #1;
        check(16'(irq_service), 16'h0001);
        irq_pending <= 1'b0;
        setup(8'h00, 8'h00, 8'h7F, 8'hFF, 16'h0000);
        run(8'h5E, 16'h0004);
        check({res_lo, flags_out}, 16'h80BF);
        check(16'(work_reg), 16'h0005);
        check({7'h00, wr_seen, 7'h00, res_word}, 16'h0100);
        setup(8'h00, 8'h00, 8'hFF, 8'hFF, 16'h0000);
        run(ltx_pkg::OP_INC, 16'h0004);
        check({res_lo, flags_out}, 16'h00CF);
        setup(8'h00, 8'h00, 8'h00, 8'h00, 16'h0000);
        run(ltx_pkg::OP_INC_IR, 16'h0004);
        check({res_lo, flags_out}, 16'h0100);
        setup(8'h00, 8'h7F, 8'hFF, 8'hFF, 16'h0000);
        run(ltx_pkg::OP_ADD1_W, 16'h0008);
        check({res_hi, res_lo}, 16'h8000);
        check({7'h00, wr_seen, 7'h00, res_word}, 16'h0101);
        check(16'(flags_out & 8'hBF), 16'h00BF);
        setup(8'h00, 8'hFF, 8'hFF, 8'h00, 16'h0000);
        run(ltx_pkg::OP_ADD1_W, 16'h0008);
        check({res_hi, res_lo}, 16'h0000);
        check(16'(flags_out & 8'hBF), 16'h0000);
        thread(ltx_pkg::OP_ENTER, 16'h0101, 16'h0103, 16'hFFFE, 16'h3D11);
        check(push_word, 16'h0000);
        thread(ltx_pkg::OP_ENTER, 16'h0240, 16'h0242, 16'hFFFC, 16'h7C12);
        check(push_word, 16'h0103);
        thread(ltx_pkg::OP_EXIT, 16'h0500, 16'h0105, 16'hFFFE, 16'h3F11);
        thread(ltx_pkg::OP_EXIT, 16'h0500, 16'h0002, 16'h0000, 16'h3C10);
        // wake request at count 6, two sync flops, then done two cycles later
        run(ltx_pkg::OP_HALT, 16'h000A);
        irq_req <= 1'b0;
        @(posedge ref_clk);
        #1;
        check(16'(cpu_clk_en), 16'h0001);
        stop_test();
    end
endmodule : loop_thread_incr_instr_exec_tb
`default_nettype wire
